/* rtl/itm_cfg.svh */
// Purpose: offsets, field positions, reset values and counts of the strobe timer
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one word per register
// Notes: definitions only
`ifndef ITM_CFG_SVH
`define ITM_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define ITM_OFS_MISC 8'h00
`define ITM_OFS_TIMING0 8'h04
`define ITM_OFS_CMD 8'h1C

// ************************************************************
// field positions
// ************************************************************
`define ITM_MISC_OVR_BIT 0
`define ITM_MISC_HOLD_LO 4
`define ITM_MISC_HOLD_HI 7
`define ITM_CMD_TYPE_LO 0
`define ITM_CMD_TYPE_HI 1
`define ITM_CMD_WR_BIT 2
`define ITM_CMD_ADDR_LO 4
`define ITM_CMD_ADDR_HI 6
`define ITM_CMD_DATA_LO 16
`define ITM_CMD_DATA_HI 31

// ************************************************************
// transfer type codes
// ************************************************************
`define ITM_TYPE_TASK 2'h0
`define ITM_TYPE_PIO 2'h1
`define ITM_TYPE_MDMA 2'h2

// ************************************************************
// reset values and fallback counts used while override is off
// ************************************************************
`define ITM_RST_COUNT 8'h00
`define ITM_RST_HOLD 4'h0
`define ITM_DFLT_COUNT 8'hFF
`define ITM_DFLT_HOLD 4'hF
`define ITM_NUM_TIMING 6

`endif

/* rtl/itm_pkg.sv */
// Purpose: types shared by the strobe timer files
// Assumes: nothing beyond the cfg header
// Notes: constants live in itm_cfg.svh
package itm_pkg;

  // access sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_HOLD, ST_RECOVER} itm_state_t;

  // one timing count
  typedef logic [7:0] itm_count_t;

endpackage

/* rtl/itm_timer.sv */
// Purpose: loadable down counter timing one phase of an access
// Assumes: load value N keeps expired low for N cycles, so a phase lasts N+1
// Notes: holds at zero until reloaded
`timescale 1ns/1ns
module itm_timer
  import itm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic load,
  input wire itm_count_t load_val,
  // status
  output logic expired
);

  itm_count_t cnt_reg;
  itm_count_t cnt_next;

  // reload wins over the decrement
  assign cnt_next = load ? load_val : ((cnt_reg != 8'h00) ? (cnt_reg - 8'h01) : cnt_reg);
  assign expired = (cnt_reg == 8'h00);

  // count register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end

endmodule

/* rtl/itm_top.sv */
// Purpose: strobe, hold and recovery timing for host-side ATA register, PIO and DMA cycles
// Assumes: 100 MHz clk_sys, software reaches registers over Avalon-MM
// Notes: one access per command write; no FIFO or DMA engine here
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "itm_cfg.svh"
module itm_top
  import itm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // ata strobes and select
  output logic host_read_strobe_n,
  output logic host_write_strobe_n,
  output logic ata_dmack_n,
  output logic [2:0] ata_addr,
  // ata data bus, split three ways
  input wire logic [15:0] ata_data_in,
  output logic [15:0] ata_data_out,
  output logic ata_data_oe
);

  // ************************************************************
  // registers
  // ************************************************************
  logic wait_reg, ovr_reg, act_wr_reg;
  logic [31:0] rdata_reg;
  logic [3:0] hold_reg;
  itm_count_t timing_reg [0:`ITM_NUM_TIMING-1];
  itm_state_t state_reg, state_next;
  logic [1:0] act_type_reg;
  itm_count_t act_stb_reg, act_rcv_reg, act_hold_reg;
  logic [15:0] sync1_reg, sync2_reg, rd_data_reg, dout_reg;
  logic rd_n_reg, wr_n_reg, dmack_n_reg, oe_reg;
  logic [2:0] addr_reg;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire req = avs_read | avs_write;
  wire done = req & ~wait_reg;
  wire [5:0] word = avs_address[7:2];
  wire hit_misc = (avs_address == `ITM_OFS_MISC);
  wire hit_cmd = (avs_address == `ITM_OFS_CMD);
  wire [5:0] tim_idx = word - 6'h01;
  wire hit_tim = (word >= 6'h01) && (word <= 6'h06) && (avs_address[1:0] == 2'h0);
  wire busy = (state_reg != ST_IDLE);
  // a command write stalls until the sequencer is idle: back-pressure to software
  wire stall = avs_write & hit_cmd & busy;
  wire wr_done = done & avs_write;
  wire go = wr_done & hit_cmd;
  wire [1:0] cmd_type = avs_writedata[`ITM_CMD_TYPE_HI:`ITM_CMD_TYPE_LO];
  wire cmd_wr = avs_writedata[`ITM_CMD_WR_BIT];
  // read data selection, unmapped reads give zero
  wire [31:0] rd_misc = {24'h000000, hold_reg, 3'h0, ovr_reg};
  wire [31:0] rd_tim = {24'h000000, timing_reg[tim_idx[2:0]]};
  wire [31:0] rd_stat = {rd_data_reg, 15'h0000, busy};
  wire [31:0] rd_mux = hit_misc ? rd_misc : (hit_tim ? rd_tim : (hit_cmd ? rd_stat : 32'h00000000));
  // bus handshake: waitrequest drops for one cycle, one cycle after the request or after a stalled command write finds the sequencer idle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      wait_reg <= ~(req & wait_reg & ~stall);
      rdata_reg <= rd_mux;
    end
  end
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  // misc control: override enable and shared write hold, both clear at reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ovr_reg <= 1'b0;
      hold_reg <= `ITM_RST_HOLD;
    end
    else if (wr_done && hit_misc && avs_byteenable[0])
    begin
      ovr_reg <= avs_writedata[`ITM_MISC_OVR_BIT];
      hold_reg <= avs_writedata[`ITM_MISC_HOLD_HI:`ITM_MISC_HOLD_LO];
    end
  end
  // six timing counts: strobe then recovery for task, pio, mdma
  genvar gi;
  generate
    for (gi = 0; gi < `ITM_NUM_TIMING; gi = gi + 1)
    begin : g_tim
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          timing_reg[gi] <= `ITM_RST_COUNT;
        else if (wr_done && hit_tim && avs_byteenable[0] && (tim_idx == 6'(gi)))
          timing_reg[gi] <= avs_writedata[7:0];
      end
    end
  endgenerate

  // ************************************************************
  // count selection
  // ************************************************************
  // unknown type code 3 runs with task file timing
  wire [2:0] base = (cmd_type == `ITM_TYPE_MDMA) ? 3'h4 : ((cmd_type == `ITM_TYPE_PIO) ? 3'h2 : 3'h0);
  // fallback counts are the slowest possible, safe but far from full speed
  wire [7:0] sel_stb = ovr_reg ? timing_reg[base] : `ITM_DFLT_COUNT;
  wire [7:0] sel_rcv = ovr_reg ? timing_reg[base + 3'h1] : `ITM_DFLT_COUNT;
  wire [7:0] sel_hold = {4'h0, (ovr_reg ? hold_reg : `ITM_DFLT_HOLD)};

  // ************************************************************
  // access sequencer
  // ************************************************************
  logic t_load, t_exp;
  itm_count_t t_val;
  itm_timer u_timer
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(t_load),
    .load_val(t_val),
    .expired(t_exp)
  );
  // each phase loads value N and lasts N+1 cycles
  always_comb
  begin
    state_next = state_reg;
    t_load = 1'b0;
    t_val = 8'h00;
    case (state_reg)
      ST_IDLE:
        if (go)
        begin
          state_next = ST_STROBE;
          t_load = 1'b1;
          t_val = sel_stb;
        end
      ST_STROBE:
        if (t_exp)
        begin
          t_load = 1'b1;
          if (act_wr_reg)
          begin
            state_next = ST_HOLD;
            t_val = act_hold_reg;
          end
          else
          begin
            state_next = ST_RECOVER;
            t_val = act_rcv_reg;
          end
        end
      ST_HOLD:
        if (t_exp)
        begin
          state_next = ST_RECOVER;
          t_load = 1'b1;
          t_val = act_rcv_reg;
        end
      ST_RECOVER:
        if (t_exp)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end
  // state and per-access snapshot; reprogramming mid-access cannot tear a cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      act_type_reg <= `ITM_TYPE_TASK;
      act_wr_reg <= 1'b0;
      act_stb_reg <= `ITM_RST_COUNT;
      act_rcv_reg <= `ITM_RST_COUNT;
      act_hold_reg <= `ITM_RST_COUNT;
    end
    else
    begin
      state_reg <= state_next;
      if (go)
      begin
        act_type_reg <= cmd_type;
        act_wr_reg <= cmd_wr;
        act_stb_reg <= sel_stb;
        act_rcv_reg <= sel_rcv;
        act_hold_reg <= sel_hold;
      end
    end
  end

  // ************************************************************
  // pin side
  // ************************************************************
  wire wr_next = go ? cmd_wr : act_wr_reg;
  wire [1:0] type_next = go ? cmd_type : act_type_reg;
  wire stb_next = (state_next == ST_STROBE);
  wire drive_next = ((state_next == ST_STROBE) || (state_next == ST_HOLD)) && wr_next;
  // read data taken on the last strobe cycle, two cycles stale through the synchroniser
  wire capture = (state_reg == ST_STROBE) && t_exp && !act_wr_reg;
  // data input synchroniser
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      rd_data_reg <= 16'h0000;
    end
    else
    begin
      sync1_reg <= ata_data_in;
      sync2_reg <= sync1_reg;
      if (capture)
        rd_data_reg <= sync2_reg;
    end
  end
  // strobes, dmack and data enable registered from the next state; address and data word loaded from the command at go
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      dmack_n_reg <= 1'b1;
      addr_reg <= 3'h0;
      dout_reg <= 16'h0000;
      oe_reg <= 1'b0;
    end
    else
    begin
      rd_n_reg <= ~(stb_next & ~wr_next);
      wr_n_reg <= ~(stb_next & wr_next);
      dmack_n_reg <= ~((state_next != ST_IDLE) && (type_next == `ITM_TYPE_MDMA));
      oe_reg <= drive_next;
      if (go)
      begin
        addr_reg <= avs_writedata[`ITM_CMD_ADDR_HI:`ITM_CMD_ADDR_LO];
        dout_reg <= avs_writedata[`ITM_CMD_DATA_HI:`ITM_CMD_DATA_LO];
      end
    end
  end
  assign host_read_strobe_n = rd_n_reg;
  assign host_write_strobe_n = wr_n_reg;
  assign ata_dmack_n = dmack_n_reg;
  assign ata_addr = addr_reg;
  assign ata_data_out = dout_reg;
  assign ata_data_oe = oe_reg;

  // ************************************************************
  // checks
  // ************************************************************
  wire strobe_on = ~rd_n_reg | ~wr_n_reg;
  wire in_rcv = (state_reg == ST_RECOVER);
  wire hold_on = oe_reg & ~strobe_on;
  logic [8:0] on_cnt, rcv_cnt, hold_cnt;
  wire [8:0] exp_stb = {1'b0, act_stb_reg} + 9'h001;
  wire [8:0] exp_rcv = {1'b0, act_rcv_reg} + 9'h001;
  wire [8:0] exp_hold = {1'b0, act_hold_reg} + 9'h001;
  // cycle counters read only by the assertions
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      on_cnt <= 9'h000;
      rcv_cnt <= 9'h000;
      hold_cnt <= 9'h000;
    end
    else
    begin
      on_cnt <= strobe_on ? on_cnt + 9'h001 : 9'h000;
      rcv_cnt <= in_rcv ? rcv_cnt + 9'h001 : 9'h000;
      hold_cnt <= hold_on ? hold_cnt + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_strobe_end;
    $fell(strobe_on);
  endsequence
  sequence s_rcv_end;
    $fell(in_rcv);
  endsequence
  sequence s_hold_end;
    $fell(hold_on);
  endsequence
  a_task_strobe_width: assert property (s_strobe_end ##0 (act_type_reg == `ITM_TYPE_TASK) |-> on_cnt == exp_stb)
    else $error("task strobe width wrong");
  a_task_recovery_len: assert property (s_rcv_end ##0 (act_type_reg == `ITM_TYPE_TASK) |-> rcv_cnt == exp_rcv)
    else $error("task recovery length wrong");
  a_pio_strobe_width: assert property (s_strobe_end ##0 (act_type_reg == `ITM_TYPE_PIO) |-> on_cnt == exp_stb)
    else $error("pio strobe width wrong");
  a_pio_recovery_len: assert property (s_rcv_end ##0 (act_type_reg == `ITM_TYPE_PIO) |-> rcv_cnt == exp_rcv)
    else $error("pio recovery length wrong");
  a_mdma_strobe_width: assert property (s_strobe_end ##0 (act_type_reg == `ITM_TYPE_MDMA) |-> on_cnt == exp_stb)
    else $error("dma strobe width wrong");
  a_mdma_recovery_len: assert property (s_rcv_end ##0 (act_type_reg == `ITM_TYPE_MDMA) |-> rcv_cnt == exp_rcv)
    else $error("dma recovery length wrong");
  a_zero_count_one: assert property ($rose(strobe_on) && (act_stb_reg == 8'h00) |=> !strobe_on)
    else $error("zero count not one cycle");
  a_task_write_hold: assert property (s_hold_end ##0 (act_type_reg == `ITM_TYPE_TASK) |-> hold_cnt == exp_hold)
    else $error("task write hold wrong");
  a_pio_write_hold: assert property (s_hold_end ##0 (act_type_reg == `ITM_TYPE_PIO) |-> hold_cnt == exp_hold)
    else $error("pio write hold wrong");
  a_mdma_write_hold: assert property (s_hold_end ##0 (act_type_reg == `ITM_TYPE_MDMA) |-> hold_cnt == exp_hold)
    else $error("dma write hold wrong");
  a_reset_ovr_clear: assert property ($fell(rst) |-> !ovr_reg)
    else $error("override set after reset");
  a_phase_order_seq: assert property (in_rcv |-> !strobe_on && !oe_reg)
    else $error("strobe or data during recovery");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule

/* tb/itm_drive_model.sv */
// Purpose: behavioural attached drive answering the host strobes
// Assumes: the data bus has no pull, so a released bus shows the inverted word
// Notes: write data is latched as the write strobe rises
`timescale 1ns/1ns
module itm_drive_model
(
  // clock and strobes
  input wire logic clk_sys,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  // address and data
  input wire logic [2:0] ata_addr,
  input wire logic [15:0] ata_data_out,
  output logic [15:0] ata_data_in,
  output logic [15:0] wr_seen
);
  logic [15:0] rd_word;
  logic wr_q;
  // ****************
  // read answer
  // ****************
  assign rd_word = 16'h5AC0 ^ {13'h0000, ata_addr};
  // inverse when idle, so a sample taken off the strobe is caught
  assign ata_data_in = host_read_strobe_n ? ~rd_word : rd_word;
  // latch on the rising write strobe, as a real drive does
  always @(posedge clk_sys)
  begin
    wr_q <= host_write_strobe_n;
    if (host_write_strobe_n && !wr_q)
      wr_seen <= ata_data_out;
  end
endmodule

/* tb/itm_top_tb.sv */
// Purpose: self-checking bench for the strobe timer
// Assumes: command and status layout of itm_cfg.svh
// Notes: strobe, hold, gap and select lengths are measured at the pins
`timescale 1ns/1ns
`include "itm_cfg.svh"
module itm_top_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q, cmd;
  logic avs_waitrequest, host_read_strobe_n, host_write_strobe_n, ata_dmack_n, ata_data_oe;
  logic [2:0] ata_addr, exp_addr;
  logic [15:0] ata_data_in, ata_data_out, wr_seen, exp_data;
  logic [7:0] cnt [6] = '{8'h03, 8'h00, 8'h05, 8'h02, 8'h04, 8'h01};
  logic stb_q = 1'b0;
  logic dm_q = 1'b1;
  int n_errors = 0;
  int n_checks = 0;
  int cs = 0, ch = 0, cg = 0, cd = 0, s_len = 0, g_len = 0, d_len = 0, bad = 0;
  int k, sv, rv, hv;

  itm_top dut_u (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .host_read_strobe_n,
    .host_write_strobe_n, .ata_dmack_n, .ata_addr, .ata_data_in, .ata_data_out, .ata_data_oe);
  itm_drive_model model_u (.clk_sys, .host_read_strobe_n, .host_write_strobe_n,
    .ata_addr, .ata_data_out, .ata_data_in, .wr_seen);

  // 100 MHz
  always #5 clk_sys = ~clk_sys;

  // ****************
  // pin monitor
  // ****************
  // lengths restart at each strobe, so after a pair they describe the second access
  always @(posedge clk_sys)
  begin
    if (!host_read_strobe_n || !host_write_strobe_n)
    begin
      if (!stb_q)
      begin
        g_len = cg;
        cs = 0;
        ch = 0;
      end
      cs++;
      cg = 0;
      bad += (ata_addr !== exp_addr) + (!host_write_strobe_n && ata_data_oe !== 1'b1);
    end
    else
    begin
      if (stb_q) s_len = cs;
      cg++;
      ch += (ata_data_oe === 1'b1);
    end
    if (ata_data_oe === 1'b1 && ata_data_out !== exp_data) bad++;
    if (ata_dmack_n === 1'b0) cd++;
    else if (!dm_q)
    begin
      d_len = cd;
      cd = 0;
    end
    stb_q = !host_read_strobe_n || !host_write_strobe_n;
    dm_q = ata_dmack_n;
  end

  // ****************
  // tasks
  // ****************
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    t = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && t < 2000)
    begin
      @(posedge clk_sys);
      t++;
    end
    // a wait that ran out counts as a mismatch
    chk_eq("bus answer", 32'h0, {31'h0, avs_waitrequest});
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_ge(input string nm, input int e, input int g);
    n_checks++;
    if (g < e)
    begin
      n_errors++;
      $display("Error %s expected at least %0d seen %0d", nm, e, g);
    end
  endtask

  // poll status until busy clears; bounded
  task automatic idle(output logic [31:0] st);
    int t;
    t = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && t < 300)
    begin
      bus(1'b1, `ITM_OFS_CMD, 32'h0, st);
      t++;
    end
    chk_eq("busy clear", 32'h0, {31'h0, st[0]});
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far beyond the roughly one thousand cycles the run needs
  initial
  begin
    #500000;
    n_errors++;
    conclude();
  end

  // ****************
  // tests
  // ****************
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // control and counts clear after reset; a hole ignores writes
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, 8'(4 * i), 32'h0, q);
      chk_eq("reset value", 32'h0, q);
    end
    bus(1'b0, 8'h20, 32'hFFFFFFFF, q);
    bus(1'b1, 8'h20, 32'h0, q);
    chk_eq("unmapped", 32'h0, q);
    // override off: slow fallback counts govern the access
    exp_addr = 3'h5;
    exp_data = 16'h1234;
    bus(1'b0, `ITM_OFS_CMD, {exp_data, 9'h000, exp_addr, 1'b0, 1'b1, 2'h0}, q);
    idle(q);
    chk_eq("fallback strobe", 32'h100, s_len);
    chk_eq("fallback hold", 32'h10, ch);
    // program counts; upper bits must read back as zero
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, 8'(4 + 4 * i), {24'hA5A5A5, cnt[i]}, q);
      bus(1'b1, 8'(4 + 4 * i), 32'h0, q);
      chk_eq("count readback", {24'h000000, cnt[i]}, q);
    end
    // two hold settings, every type code, both directions, accesses in pairs
    foreach (cnt[j])
    begin
      if (j > 1) break;
      hv = (j == 0) ? 2 : 0;
      bus(1'b0, `ITM_OFS_MISC, 32'(hv * 16 + 1), q);
      for (int ty = 0; ty < 4; ty++)
      begin
        for (int wr = 0; wr < 2; wr++)
        begin
          k = (ty == 3) ? 0 : ty;
          sv = cnt[2 * k];
          rv = cnt[2 * k + 1];
          exp_addr = 3'(ty + 1);
          exp_data = 16'hC0DE ^ 16'(ty * 16 + wr);
          cmd = {exp_data, 9'h000, exp_addr, 1'b0, wr[0], ty[1:0]};
          d_len = 0;
          bad = 0;
          // second command stalls until the first has recovered
          bus(1'b0, `ITM_OFS_CMD, cmd, q);
          bus(1'b0, `ITM_OFS_CMD, cmd, q);
          idle(q);
          chk_eq("strobe width", sv + 1, s_len);
          chk_eq("write hold", wr ? hv + 1 : 0, ch);
          chk_ge("gap", rv + 1 + (wr ? hv + 1 : 0), g_len);
          chk_eq("dma select", (k == 2) ? sv + rv + 2 + (wr ? hv + 1 : 0) : 0, d_len);
          chk_eq("pin data", 32'h0, bad);
          if (wr)
            chk_eq("drive word", exp_data, wr_seen);
          else
            chk_eq("read word", 16'h5AC0 ^ exp_addr, q[31:16]);
        end
      end
    end
    // shortest strobe: count 0 must give exactly one cycle
    bus(1'b0, `ITM_OFS_TIMING0, 32'h0, q);
    exp_addr = 3'h6;
    exp_data = 16'h0F0F;
    bad = 0;
    bus(1'b0, `ITM_OFS_CMD, {exp_data, 9'h000, exp_addr, 1'b0, 1'b1, 2'h0}, q);
    bus(1'b0, `ITM_OFS_CMD, {exp_data, 9'h000, exp_addr, 1'b0, 1'b1, 2'h0}, q);
    idle(q);
    chk_eq("zero strobe", 32'h1, s_len);
    chk_eq("zero pin data", 32'h0, bad);
    chk_eq("zero drive word", exp_data, wr_seen);
    // lane 0 disabled: the count must stay as it was
    avs_byteenable <= 4'hE;
    bus(1'b0, `ITM_OFS_TIMING0, 32'h7, q);
    avs_byteenable <= 4'hF;
    bus(1'b1, `ITM_OFS_TIMING0, 32'h0, q);
    chk_eq("lane gate", 32'h0, q);
    conclude();
  end
endmodule
